// ===== dssfr_consts.vh
// constants for the device specific sfr bank
// Summary of operation
// - 0x55 starts page erase after page write
// - 0xAA mass erase needs enable and debug
// - other erase patterns are ignored
// - page address 0 to 127, resets zero
// - write enable steers external moves to flash
// - write enable clears after each flash byte
// - write enable locked while interrupts enabled
// - readout lock blocks external flash reads
// - readout lock clears only on reset
// - bit 7 reads one during preboot
// - transmit code starts eeprom byte send
// - flag 0 set by transfer event, sticky
// - flag 1 set by periodic tick, sticky
// - input levels read live, no memory
`ifndef DSSFR_CONSTS_VH
`define DSSFR_CONSTS_VH
`define DSSFR_ADR_ERASE      8'h94
`define DSSFR_ADR_EEPROM_BYTE     8'h9e
`define DSSFR_ADR_EEPROM_COMMAND     8'h9f
`define DSSFR_ADR_FLASHCTL   8'hb2
`define DSSFR_ADR_PAGE       8'hb7
`define DSSFR_ADR_FLAGS      8'he8
`define DSSFR_ADR_INLEVELS   8'hf8
`define DSSFR_PAT_PAGE       8'h55
`define DSSFR_PAT_MASS       8'haa
`define DSSFR_PAGE_RST       7'h00
`define DSSFR_PAGE_W         7
`define DSSFR_BIT_PWE        0
`define DSSFR_BIT_MEEN       1
`define DSSFR_BIT_LOCK       6
`define DSSFR_BIT_PREBOOT    7
`define DSSFR_BIT_XFER       0
`define DSSFR_BIT_TICK       1
`define DSSFR_EE_TX_CODE     8'h01
`endif

// ===== dssfr_bank.v
// device specific special function register bank
`timescale 1ns/1ns
`include "dssfr_consts.vh"
module dssfr_bank (
    input  wire       sys_clk_i,
    input  wire       sys_rst_i,
    input  wire [7:0] sfr_addr_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_wr_i,
    input  wire       sfr_rd_i,
    output reg  [7:0] sfr_rdata_o,
    input  wire       global_int_en_i,
    input  wire       debug_port_en_i,
    input  wire       preboot_active_i,
    input  wire       flash_byte_written_i,
    input  wire       engine_transfer_event_i,
    input  wire       periodic_tick_event_i,
    input  wire [6:0] external_interrupt_input_i,
    input  wire [7:0] eeprom_status_i,
    output reg        page_erase_start_o,
    output reg        mass_erase_start_o,
    output reg  [6:0] erase_page_number_o,
    output reg        program_write_enable_o,
    output reg        readout_lock_o,
    output reg        eeprom_tx_start_o,
    output reg  [7:0] eeprom_byte_o,
    output reg  [7:0] eeprom_command_o,
    output reg  [1:0] irq_flags_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [6:0] ext_meta_ff;
reg [6:0] ext_sync_ff;
reg [2:0] evt_meta_ff;
reg [2:0] evt_sync_ff;
reg [1:0] evt_prev_ff;
reg       preboot_meta_ff;
reg       preboot_sync_ff;
reg       debug_meta_ff;
reg       debug_sync_ff;

// interrupt input levels, read back live through two flops
always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        ext_meta_ff <= 7'h00;
        ext_sync_ff <= 7'h00;
    end else begin
        ext_meta_ff <= external_interrupt_input_i;
        ext_sync_ff <= ext_meta_ff;
    end
end

// event lines; a third flop keeps the last level of the transfer and tick lines for edge detection
always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        evt_meta_ff <= 3'h0;
        evt_sync_ff <= 3'h0;
        evt_prev_ff <= 2'h0;
    end else begin
        evt_meta_ff <= {flash_byte_written_i, periodic_tick_event_i,
                        engine_transfer_event_i};
        evt_sync_ff <= evt_meta_ff;
        evt_prev_ff <= evt_sync_ff[1:0];
    end
end

// preboot and debug enable are slow levels
always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        preboot_meta_ff <= 1'b0;
        preboot_sync_ff <= 1'b0;
        debug_meta_ff   <= 1'b0;
        debug_sync_ff   <= 1'b0;
    end else begin
        preboot_meta_ff <= preboot_active_i;
        preboot_sync_ff <= preboot_meta_ff;
        debug_meta_ff   <= debug_port_en_i;
        debug_sync_ff   <= debug_meta_ff;
    end
end

// rising edges mark the interrupt events
wire xfer_evt = evt_sync_ff[0] & ~evt_prev_ff[0];
wire tick_evt = evt_sync_ff[1] & ~evt_prev_ff[1];
// flash writer holds its done level one cycle per byte
wire byte_done = evt_sync_ff[2];

////////////////////////////////////////////////////////////////////////////////
// write decode
function is_wr;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
        is_wr = wr & (addr == target);
    end
endfunction

wire wr_erase = is_wr(sfr_addr_i, `DSSFR_ADR_ERASE, sfr_wr_i);
wire wr_eed   = is_wr(sfr_addr_i, `DSSFR_ADR_EEPROM_BYTE, sfr_wr_i);
wire wr_eec   = is_wr(sfr_addr_i, `DSSFR_ADR_EEPROM_COMMAND, sfr_wr_i);
wire wr_fctl  = is_wr(sfr_addr_i, `DSSFR_ADR_FLASHCTL, sfr_wr_i);
wire wr_page  = is_wr(sfr_addr_i, `DSSFR_ADR_PAGE, sfr_wr_i);
wire wr_flags = is_wr(sfr_addr_i, `DSSFR_ADR_FLAGS, sfr_wr_i);

////////////////////////////////////////////////////////////////////////////////
// flash control and erase
reg       page_armed_ff;
reg       mass_en_ff;
reg [6:0] nxt_page_number;
reg       nxt_page_armed;
reg       nxt_mass_en;
reg       nxt_pwe;
reg       nxt_lock;

wire pat_page = wr_erase & (sfr_wdata_i == `DSSFR_PAT_PAGE);
wire pat_mass = wr_erase & (sfr_wdata_i == `DSSFR_PAT_MASS);
wire go_page  = pat_page & page_armed_ff;
wire go_mass  = pat_mass & mass_en_ff & debug_sync_ff;

// a page address write arms exactly one page erase
always @* begin
    nxt_page_number = erase_page_number_o;
    nxt_page_armed  = page_armed_ff;
    if (wr_page) begin
        nxt_page_number = sfr_wdata_i[`DSSFR_PAGE_W-1:0];
        nxt_page_armed  = 1'b1;
    end else if (go_page) begin
        nxt_page_armed = 1'b0;
    end
end

// the mass erase enable is used up by the erase it allows
always @* begin
    nxt_mass_en = mass_en_ff;
    if (wr_fctl) begin
        nxt_mass_en = sfr_wdata_i[`DSSFR_BIT_MEEN];
    end else if (go_mass) begin
        nxt_mass_en = 1'b0;
    end
end

// with interrupts on, only the enable bit of a write is dropped
always @* begin
    nxt_pwe = program_write_enable_o;
    if (wr_fctl & ~global_int_en_i) begin
        nxt_pwe = sfr_wdata_i[`DSSFR_BIT_PWE];
    end else if (byte_done) begin
        nxt_pwe = 1'b0;
    end
end

// the lock only ever sets; a zero written to it is dropped
always @* begin
    nxt_lock = readout_lock_o;
    if (wr_fctl & sfr_wdata_i[`DSSFR_BIT_LOCK]) begin
        nxt_lock = 1'b1;
    end
end

// other patterns fall through with no start
always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        page_erase_start_o <= 1'b0;
        mass_erase_start_o <= 1'b0;
    end else begin
        page_erase_start_o <= go_page;
        mass_erase_start_o <= go_mass;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        erase_page_number_o <= `DSSFR_PAGE_RST;
        page_armed_ff       <= 1'b0;
    end else begin
        erase_page_number_o <= nxt_page_number;
        page_armed_ff       <= nxt_page_armed;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        mass_en_ff <= 1'b0;
    end else begin
        mass_en_ff <= nxt_mass_en;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        program_write_enable_o <= 1'b0;
    end else begin
        program_write_enable_o <= nxt_pwe;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        readout_lock_o <= 1'b0;
    end else begin
        readout_lock_o <= nxt_lock;
    end
end

////////////////////////////////////////////////////////////////////////////////
// eeprom registers
reg [7:0] nxt_eeprom_byte;
reg [7:0] nxt_eeprom_command;
wire      tx_code = wr_eec & (sfr_wdata_i == `DSSFR_EE_TX_CODE);

// the byte to send is kept until software writes a new one
always @* begin
    nxt_eeprom_byte = eeprom_byte_o;
    if (wr_eed) begin
        nxt_eeprom_byte = sfr_wdata_i;
    end
end

// every control write is kept; only the transmit code starts a send
always @* begin
    nxt_eeprom_command = eeprom_command_o;
    if (wr_eec) begin
        nxt_eeprom_command = sfr_wdata_i;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        eeprom_byte_o    <= 8'h00;
        eeprom_command_o <= 8'h00;
    end else begin
        eeprom_byte_o    <= nxt_eeprom_byte;
        eeprom_command_o <= nxt_eeprom_command;
    end
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        eeprom_tx_start_o <= 1'b0;
    end else begin
        eeprom_tx_start_o <= tx_code;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt flags: a set wins over a clear in the same cycle
// next value of one sticky flag
function flag_next;
    input flag;
    input evt;
    input wr;
    input keep;
    begin
        flag_next = evt | (flag & ~(wr & ~keep));
    end
endfunction

reg [1:0] nxt_irq_flags;

always @* begin
    nxt_irq_flags = irq_flags_o;
    nxt_irq_flags[`DSSFR_BIT_XFER] = flag_next(irq_flags_o[`DSSFR_BIT_XFER], xfer_evt,
        wr_flags, sfr_wdata_i[`DSSFR_BIT_XFER]);
    nxt_irq_flags[`DSSFR_BIT_TICK] = flag_next(irq_flags_o[`DSSFR_BIT_TICK], tick_evt,
        wr_flags, sfr_wdata_i[`DSSFR_BIT_TICK]);
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        irq_flags_o <= 2'h0;
    end else begin
        irq_flags_o <= nxt_irq_flags;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, registered
reg [7:0] nxt_rdata;

always @* begin
    nxt_rdata = 8'h00;
    case (sfr_addr_i)
        `DSSFR_ADR_EEPROM_BYTE:   nxt_rdata = eeprom_byte_o;
        `DSSFR_ADR_EEPROM_COMMAND:   nxt_rdata = eeprom_status_i;
        `DSSFR_ADR_FLASHCTL: begin
            nxt_rdata[`DSSFR_BIT_PREBOOT] = preboot_sync_ff;
            nxt_rdata[`DSSFR_BIT_LOCK]    = readout_lock_o;
            nxt_rdata[`DSSFR_BIT_PWE]     = program_write_enable_o;
        end
        `DSSFR_ADR_PAGE:     nxt_rdata = {1'b0, erase_page_number_o};
        `DSSFR_ADR_FLAGS: begin
            nxt_rdata[`DSSFR_BIT_XFER] = irq_flags_o[`DSSFR_BIT_XFER];
            nxt_rdata[`DSSFR_BIT_TICK] = irq_flags_o[`DSSFR_BIT_TICK];
        end
        `DSSFR_ADR_INLEVELS: nxt_rdata = {1'b0, ext_sync_ff};
        default:             nxt_rdata = 8'h00;
    endcase
end

always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
        sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
        sfr_rdata_o <= nxt_rdata;
    end
end

endmodule // dssfr_bank

// ===== dssfr_bank_sva.sv
// assertions for the device specific sfr bank
`timescale 1ns/1ns
module dssfr_bank_sva (
    input wire       sys_clk_i,
    input wire       sys_rst_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire       sfr_wr_i,
    input wire       global_int_en_i,
    input wire       page_erase_start_o,
    input wire       mass_erase_start_o,
    input wire [6:0] erase_page_number_o,
    input wire       program_write_enable_o,
    input wire       readout_lock_o,
    input wire       eeprom_tx_start_o,
    input wire [1:0] irq_flags_o
);
    wire w94 = sfr_wr_i && sfr_addr_i == 8'h94;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_page_pulse_one: assert property (page_erase_start_o |=> !page_erase_start_o)
        else $error("page erase pulse too long");
    a_page_cause: assert property (page_erase_start_o |-> $past(w94 && sfr_wdata_i == 8'h55))
        else $error("page erase without its pattern");
    a_mass_cause: assert property (mass_erase_start_o |-> $past(w94 && sfr_wdata_i == 8'haa))
        else $error("mass erase without its pattern");
    a_page_load: assert property (sfr_wr_i && sfr_addr_i == 8'hb7
        |=> erase_page_number_o == $past(sfr_wdata_i[6:0]))
        else $error("page number not loaded");
    a_lock_sticky: assert property (readout_lock_o |=> readout_lock_o)
        else $error("lock cleared without reset");
    a_pwe_guard: assert property ($rose(program_write_enable_o) |-> $past(!global_int_en_i
        && sfr_wr_i && sfr_addr_i == 8'hb2 && sfr_wdata_i[0]))
        else $error("write enable set illegally");
    a_xfer_sticky: assert property (irq_flags_o[0]
        && !(sfr_wr_i && sfr_addr_i == 8'he8 && !sfr_wdata_i[0]) |=> irq_flags_o[0])
        else $error("transfer flag lost");
    a_tx_cause: assert property (eeprom_tx_start_o
        |-> $past(sfr_wr_i && sfr_addr_i == 8'h9f && sfr_wdata_i == 8'h01))
        else $error("eeprom send without command");
    c_page: cover property (page_erase_start_o);
    c_mass: cover property (mass_erase_start_o);
    c_flags: cover property (irq_flags_o == 2'h3);
endmodule // dssfr_bank_sva
bind dssfr_bank dssfr_bank_sva dssfr_bank_sva_i (.*);

// ===== tb.sv
// self-checking testbench for the device specific sfr bank
`timescale 1ns/1ns
module tb;
    logic       clk, rst, wr, rd, gie, dbg, pre, fbw, xev, tev, pes, mes, pwe, lock, txs;
    logic [7:0] addr, wd, rdata, eb, ec, est, v;
    logic [6:0] ext, epn;
    logic [1:0] flg;
    int         err_count, n_tests, np, nm, nt, i;
    dssfr_bank dssfr_bank_i (.sys_clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr),
        .sfr_wdata_i(wd), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .global_int_en_i(gie), .debug_port_en_i(dbg), .preboot_active_i(pre),
        .flash_byte_written_i(fbw), .engine_transfer_event_i(xev),
        .periodic_tick_event_i(tev), .external_interrupt_input_i(ext),
        .eeprom_status_i(est), .page_erase_start_o(pes), .mass_erase_start_o(mes),
        .erase_page_number_o(epn), .program_write_enable_o(pwe),
        .readout_lock_o(lock), .eeprom_tx_start_o(txs), .eeprom_byte_o(eb),
        .eeprom_command_o(ec), .irq_flags_o(flg));
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (!rst) begin
            np += pes;
            nm += mes;
            nt += txs;
        end
    end
    task automatic chk(input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] fctl_exp(input logic p, l, w);
        return {p, l, 5'h00, w};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrt(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        @(negedge clk);
        addr = a;
        rd = 1;
        cyc(2);
        rd = 0;
        chk(rdata, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    initial begin
        #500000;
        err_count++;
        wrap_up();
    end
    initial begin
        {wr, rd, gie, dbg, fbw, xev, tev, addr, wd, ext, est} = 0;
        {err_count, n_tests, np, nm, nt} = 0;
        rst = 1;
        pre = 1;
        void'($urandom(36823));
        cyc(4);
        rst = 0;
        rdc(8'hb2, fctl_exp(1'b1, 1'b0, 1'b0));
        rdc(8'hb7, 8'h00);
        pre = 0;
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h7f : 8'($urandom % 128);
            wrt(8'hb7, v);
            chk({1'b0, epn}, v);
            v = 8'($urandom);
            wrt(8'h94, (v == 8'h55 || v == 8'haa) ? 8'h00 : v);
            wrt(8'h94, 8'h55);
            wrt(8'h94, 8'h55);
        end
        dbg = 1;
        cyc(3);
        wrt(8'hb2, 8'h02);
        wrt(8'h94, 8'haa);
        wrt(8'h94, 8'haa);
        dbg = 0;
        cyc(3);
        wrt(8'hb2, 8'h02);
        wrt(8'h94, 8'haa);
        cyc(2);
        chk(np[7:0], 8'h06);
        chk(nm[7:0], 8'h01);
        gie = 1;
        wrt(8'hb2, 8'h01);
        chk(8'(pwe), 8'h00);
        gie = 0;
        wrt(8'hb2, 8'h41);
        chk(8'(pwe), 8'h01);
        rdc(8'hb2, fctl_exp(1'b0, 1'b1, 1'b1));
        fbw = 1;
        cyc(1);
        fbw = 0;
        cyc(4);
        chk(8'(pwe), 8'h00);
        wrt(8'hb2, 8'h00);
        rdc(8'hb2, fctl_exp(1'b0, 1'b1, 1'b0));
        chk(8'(lock), 8'h01);
        v = 8'($urandom);
        wrt(8'h9e, v);
        wrt(8'h9f, 8'h01);
        wrt(8'h9f, 8'h02);
        cyc(2);
        chk(eb, v);
        chk(ec, 8'h02);
        chk(nt[7:0], 8'h01);
        rdc(8'h9e, v);
        est = 8'($urandom);
        rdc(8'h9f, est);
        xev = 1;
        tev = 1;
        cyc(2);
        xev = 0;
        tev = 0;
        cyc(6);
        chk(8'(flg), 8'h03);
        wrt(8'he8, 8'hfe);
        cyc(3);
        chk(8'(flg), 8'h02);
        wrt(8'he8, 8'hfd);
        rdc(8'he8, 8'h00);
        xev = 1;
        cyc(1);
        wrt(8'he8, 8'hfe);
        xev = 0;
        rdc(8'he8, 8'h01);
        for (i = 0; i < 4; i++) begin
            ext = 7'($urandom);
            cyc(3);
            rdc(8'hf8, {1'b0, ext});
        end
        rdc(8'h00, 8'h00);
        rst = 1;
        cyc(2);
        rst = 0;
        chk(8'(lock), 8'h00);
        chk({1'b0, epn}, 8'h00);
        chk(8'(flg), 8'h00);
        wrap_up();
    end
endmodule // tb
